/* File: logic/gfxcs_regs.sv */
// Command and status registers of the graphics function.
`timescale 1ns/1ps

// What this block does
// RL1 - Memory space accesses are claimed only while command bit 1 is set; it is writable and resets to 0.
// RL2 - I/O space accesses are claimed only while command bit 0 is set; it is writable and resets to 0.
// RL3 - Command bit 2 always reads 1 and bus mastering is always allowed.
// RL4 - Command bit 6 reads 0 and detected parity errors are ignored.
// RL5 - Command bit 4 reads 0 since memory write and invalidate is not supported.
// RL6 - Command bit 3 reads 0 and special cycles are ignored.
// RL7 - Command bit 5 reads 0 and palette writes are never snooped.
// RL8 - The command register resets to 0004h with bits 15:7 reading 0.
// RL9 - The status register is read-only and always reads 02B0h.
// RL10 - Status bits 10:9 read 01 for medium select timing.
// RL11 - Status bits 15 to 12 read 0.
// RL12 - The system error pin is never driven and status bit 11 reads 0.
// RL13 - Status bit 8 reads 0 as no parity checking is done.
// RL14 - Status bit 7 reads 1 since back-to-back target accesses are taken.
// RL15 - Status bit 5 reads 1 and status bit 6 reads 0.
// RL16 - Status bit 4 reads 1 to flag the capability pointer; bits 3:0 read 0.
// RL17 - Writes to read-only or reserved bits of either register do nothing.
module gfxcs_regs (
  input wire logic core_clk_i,         // 40 MHz clock
  input wire logic rst_b_i,            // Async reset, active low
  input wire logic [7:0] cfg_addr_i,   // Config byte address, bits 1:0 ignored
  input wire logic [3:0] cfg_be_i,     // Byte enables, active high
  input wire logic cfg_wr_i,           // Config write strobe
  input wire logic cfg_rd_i,           // Config read strobe
  input wire logic [31:0] cfg_wdata_i, // Config write data
  input wire logic mem_hit_i,          // Decoded memory space access
  input wire logic io_hit_i,           // Decoded I/O space access
  input wire logic parity_err_i,       // Parity error seen on the bus
  output logic [31:0] cfg_rdata_o,     // Config read data
  output logic cfg_rvalid_o,           // Read data valid, one cycle
  output logic mem_space_enable_o,     // Memory space enable bit
  output logic io_space_enable_o,      // I/O space enable bit
  output logic bus_master_allow_o,     // Bus mastering allowed
  output logic mem_claim_o,            // Memory access claimed
  output logic io_claim_o,             // I/O access claimed
  output logic serr_o,                 // System error pin output
  output logic serr_oe_b_o             // System error enable, active low
);

  logic cmd_hit;
  logic [15:0] next_command;
  logic [15:0] status_word;

  // Builds the command word from the two writable bits; all else is fixed.
  function automatic logic [15:0] command_word(input logic mem_en,
                                               input logic io_en);
    logic [15:0] w;
    w = gfxcs_pkg::CMD_RESET; // [RL4] [RL5] [RL6] [RL7] [RL8]
    w[gfxcs_pkg::CMD_MEM_BIT] = mem_en;
    w[gfxcs_pkg::CMD_IO_BIT] = io_en;
    return w;
  endfunction : command_word

  // Both registers share one dword; status occupies the upper half.
  assign cmd_hit = (cfg_addr_i[7:2] == gfxcs_pkg::CMD_OFFSET[7:2]);
  assign next_command = command_word(mem_space_enable_o, io_space_enable_o);

  // Status is wiring only, so no bus event can ever raise one of its flags.
  always_comb begin // [RL9]
    status_word = 16'h0000; // [RL11] [RL12] [RL13] [RL15]
    status_word[gfxcs_pkg::STS_SEL_TIME_LO +: 2] =
      gfxcs_pkg::SEL_TIME_MEDIUM; // [RL10]
    status_word[gfxcs_pkg::STS_B2B_BIT] = 1'b1; // [RL14]
    status_word[gfxcs_pkg::STS_66_BIT] = 1'b1; // [RL15]
    status_word[gfxcs_pkg::STS_CAP_BIT] = 1'b1; // [RL16]
  end

  // Only bits 1:0 take write data; byte 1 and the status half drop it.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_space_enable_o <= gfxcs_pkg::CMD_RESET[gfxcs_pkg::CMD_MEM_BIT];
      io_space_enable_o <= gfxcs_pkg::CMD_RESET[gfxcs_pkg::CMD_IO_BIT];
    end else if (cfg_wr_i && cmd_hit && cfg_be_i[0]) begin // [RL17]
      mem_space_enable_o <= cfg_wdata_i[gfxcs_pkg::CMD_MEM_BIT]; // [RL1]
      io_space_enable_o <= cfg_wdata_i[gfxcs_pkg::CMD_IO_BIT]; // [RL2]
    end
  end

  // Read answer one cycle after the strobe; other dwords read as zero.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_rdata_o <= 32'h0000_0000;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i && cmd_hit) begin
        cfg_rdata_o <= {status_word, next_command}; // [RL8]
      end else begin
        cfg_rdata_o <= 32'h0000_0000;
      end
    end
  end

  // Bus mastering is permanently on and the error pin is never driven.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_master_allow_o <= 1'b1;
      serr_o <= 1'b0;
      serr_oe_b_o <= 1'b1;
    end else begin
      bus_master_allow_o <= 1'b1; // [RL3]
      serr_o <= 1'b0;
      serr_oe_b_o <= 1'b1; // [RL12]
    end
  end

  // Claims register the gated hit so both spaces share one latency.
  gfxcs_target_gate u_mem_gate (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .enable_i(mem_space_enable_o), // [RL1]
    .hit_i(mem_hit_i),
    .claim_o(mem_claim_o)
  );

  gfxcs_target_gate u_io_gate (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .enable_i(io_space_enable_o), // [RL2]
    .hit_i(io_hit_i),
    .claim_o(io_claim_o)
  );

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence cmd_read_s;
    cfg_rd_i && cmd_hit;
  endsequence

  sequence cmd_write_s;
    cfg_wr_i && cmd_hit && cfg_be_i[0];
  endsequence

  sequence read_answer_s;
    cfg_rvalid_o;
  endsequence

  sequence write_then_read_s;
    cmd_write_s ##1 !cfg_wr_i ##1 cmd_read_s;
  endsequence

  sequence reset_release_s;
    $rose(rst_b_i);
  endsequence

  mem_claim_gate_a: assert property ( // [RL1]
    mem_hit_i && !mem_space_enable_o |=> !mem_claim_o)
    else $error("memory access claimed while disabled");

  mem_enable_write_a: assert property ( // [RL1]
    write_then_read_s |=> read_answer_s
      and cfg_rdata_o[1] == $past(cfg_wdata_i[1], 3))
    else $error("memory enable not written");

  io_claim_gate_a: assert property ( // [RL2]
    io_hit_i ##0 io_space_enable_o |=> io_claim_o)
    else $error("enabled I/O access not claimed");

  io_disable_gate_a: assert property ( // [RL2]
    io_hit_i && !io_space_enable_o |=> !io_claim_o)
    else $error("I/O access claimed while disabled");

  bus_master_on_a: assert property ( // [RL3]
    cmd_read_s |=> cfg_rdata_o[2] && bus_master_allow_o)
    else $error("bus master bit not set");

  parity_resp_off_a: assert property ( // [RL4]
    cmd_read_s |=> !cfg_rdata_o[6])
    else $error("parity response bit set");

  mwi_bit_zero_a: assert property ( // [RL5]
    cmd_read_s |=> !cfg_rdata_o[4])
    else $error("write invalidate bit set");

  special_bit_zero_a: assert property ( // [RL6]
    cmd_read_s |=> !cfg_rdata_o[3])
    else $error("special cycle bit set");

  palette_bit_zero_a: assert property ( // [RL7]
    cmd_read_s |=> !cfg_rdata_o[5])
    else $error("palette snoop bit set");

  cmd_upper_zero_a: assert property ( // [RL8]
    cmd_read_s |=> cfg_rdata_o[15:7] == 9'h000)
    else $error("command upper bits not zero");

  status_const_a: assert property ( // [RL9]
    cmd_read_s |=> cfg_rdata_o[31:16] == gfxcs_pkg::STS_VALUE)
    else $error("status not constant");

  select_timing_a: assert property ( // [RL10]
    cmd_read_s |=> cfg_rdata_o[26:25] == 2'h1)
    else $error("select timing wrong");

  error_flags_zero_a: assert property ( // [RL11]
    cmd_read_s |=> cfg_rdata_o[31:28] == 4'h0)
    else $error("error status bits set");

  serr_never_a: assert property ( // [RL12]
    serr_oe_b_o && !serr_o && !$past(serr_o))
    else $error("system error driven");

  target_abort_zero_a: assert property ( // [RL12]
    cmd_read_s |=> !cfg_rdata_o[27])
    else $error("target abort bit set");

  parity_seen_zero_a: assert property ( // [RL13]
    parity_err_i ##1 cmd_read_s |=> !cfg_rdata_o[24])
    else $error("data parity bit set");

  back_to_back_a: assert property ( // [RL14]
    cmd_read_s |=> cfg_rdata_o[23])
    else $error("back-to-back bit clear");

  fast_bus_bits_a: assert property ( // [RL15]
    cmd_read_s |=> cfg_rdata_o[21] && !cfg_rdata_o[22])
    else $error("66 MHz or user format wrong");

  cap_list_a: assert property ( // [RL16]
    cmd_read_s |=> cfg_rdata_o[20] && cfg_rdata_o[19:16] == 4'h0)
    else $error("capability bits wrong");

  ro_write_ignored_a: assert property ( // [RL17]
    cfg_wr_i && cmd_hit && !cfg_be_i[0] |=>
      $stable(mem_space_enable_o) && $stable(io_space_enable_o))
    else $error("write without byte 0 changed enables");

  read_latency_a: assert property ( // [RL9]
    cfg_rd_i |=> cfg_rvalid_o ##1 (!cfg_rvalid_o || $past(cfg_rd_i)))
    else $error("read answer timing wrong");

  unused_parity_a: assert property ( // [RL4]
    parity_err_i && !cfg_wr_i |=>
      $stable(mem_space_enable_o) && $stable(io_space_enable_o))
    else $error("parity error changed the enables");

  // The claim path must follow the enable in both directions.
  mem_claim_on_a: assert property ( // [RL1]
    mem_hit_i ##0 mem_space_enable_o |=> mem_claim_o)
    else $error("enabled memory access not claimed");

  mem_claim_cause_a: assert property ( // [RL1]
    mem_claim_o |-> $past(mem_hit_i && mem_space_enable_o))
    else $error("memory claim without an enabled hit");

  io_claim_cause_a: assert property ( // [RL2]
    io_claim_o |-> $past(io_hit_i && io_space_enable_o))
    else $error("I/O claim without an enabled hit");

  io_enable_write_a: assert property ( // [RL2]
    write_then_read_s |=> read_answer_s
      and cfg_rdata_o[0] == $past(cfg_wdata_i[0], 3))
    else $error("I/O enable not written");

  enables_readback_a: assert property ( // [RL1]
    cmd_read_s |=> cfg_rdata_o[1:0] ==
      $past({mem_space_enable_o, io_space_enable_o}))
    else $error("enables read back wrong");

  // Every reset, early or in mid-run, must leave the access spaces shut.
  reset_mem_off_a: assert property ( // [RL1]
    reset_release_s |-> !mem_space_enable_o)
    else $error("memory enable set out of reset");

  reset_io_off_a: assert property ( // [RL2]
    reset_release_s |-> !io_space_enable_o)
    else $error("I/O enable set out of reset");

  reset_claims_a: assert property ( // [RL1]
    reset_release_s |-> !mem_claim_o && !io_claim_o)
    else $error("claim active out of reset");

  reset_master_a: assert property ( // [RL3]
    reset_release_s |-> bus_master_allow_o)
    else $error("bus master off out of reset");

  serr_reset_a: assert property ( // [RL12]
    reset_release_s |-> serr_oe_b_o && !serr_o)
    else $error("system error driven out of reset");

  master_pin_on_a: assert property ( // [RL3]
    bus_master_allow_o)
    else $error("bus master output dropped");

  // Reads outside the command dword and idle cycles must return zero.
  other_dword_zero_a: assert property ( // [RL17]
    cfg_rd_i && !cmd_hit |=> cfg_rvalid_o && cfg_rdata_o == 32'h0000_0000)
    else $error("unmapped read returned data");

  other_dword_write_a: assert property ( // [RL17]
    cfg_wr_i && !cmd_hit |=>
      $stable(mem_space_enable_o) && $stable(io_space_enable_o))
    else $error("write to another dword changed enables");

  read_idle_zero_a: assert property ( // [RL9]
    !cfg_rd_i |=> !cfg_rvalid_o && cfg_rdata_o == 32'h0000_0000)
    else $error("read answer without a read");

  read_reset_zero_a: assert property ( // [RL9]
    reset_release_s |-> !cfg_rvalid_o && cfg_rdata_o == 32'h0000_0000)
    else $error("read answer out of reset");

endmodule : gfxcs_regs

/* File: logic/gfxcs_pkg.sv */
// Constants for the graphics function command and status registers.
package gfxcs_pkg;

  // Byte offsets of the two registers in configuration space.
  localparam logic [7:0] CMD_OFFSET = 8'h04;
  localparam logic [7:0] STS_OFFSET = 8'h06;
  // Byte that holds the capability list pointer, reported by the status.
  localparam logic [7:0] CAP_PTR_OFFSET = 8'h34;

  // Command field positions.
  localparam int CMD_IO_BIT = 0;
  localparam int CMD_MEM_BIT = 1;
  localparam int CMD_BM_BIT = 2;
  localparam int CMD_SPC_BIT = 3;
  localparam int CMD_MWI_BIT = 4;
  localparam int CMD_PAL_BIT = 5;
  localparam int CMD_PAR_BIT = 6;
  localparam int CMD_STEP_BIT = 7;
  localparam int CMD_SERR_BIT = 8;
  localparam int CMD_B2B_BIT = 9;
  localparam int CMD_RSVD_LO = 10;

  // Status field positions.
  localparam int STS_CAP_BIT = 4;
  localparam int STS_66_BIT = 5;
  localparam int STS_USER_FMT_BIT = 6;
  localparam int STS_B2B_BIT = 7;
  localparam int STS_PAR_SEEN_BIT = 8;
  localparam int STS_SEL_TIME_LO = 9;
  localparam int STS_STA_BIT = 11;
  localparam int STS_RTA_BIT = 12;
  localparam int STS_RMA_BIT = 13;
  localparam int STS_SERR_SENT_BIT = 14;
  localparam int STS_PAR_ERR_BIT = 15;

  // Reset and fixed values.
  localparam logic [15:0] CMD_RESET = 16'h0004;
  localparam logic [15:0] CMD_WRITE_MASK = 16'h0003;
  localparam logic [15:0] STS_VALUE = 16'h02B0;
  localparam logic [1:0] SEL_TIME_MEDIUM = 2'h1;

endpackage : gfxcs_pkg

/* File: logic/gfxcs_target_gate.sv */
// Registered claim gate for one address space of the target.
`timescale 1ns/1ps

module gfxcs_target_gate (
  input wire logic core_clk_i, // 40 MHz clock
  input wire logic rst_b_i,    // Async reset, active low
  input wire logic enable_i,   // Space enable from the command register
  input wire logic hit_i,      // Decoded access to this space
  output logic claim_o         // Target claims the access
);

  // A disabled space never claims, so a stale hit cannot leak through.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      claim_o <= 1'b0;
    end else begin
      claim_o <= hit_i & enable_i;
    end
  end

endmodule : gfxcs_target_gate

/* File: tb/gfxcs_host_model.sv */
// Host configuration agent model that issues register cycles.
`timescale 1ns/1ps

module gfxcs_host_model (
  input wire logic core_clk_i,     // Bench clock
  input wire logic [31:0] rdata_i, // Read data from the device
  input wire logic rvalid_i,       // Read data valid
  output logic [7:0] addr_o,       // Byte address
  output logic [3:0] be_o,         // Byte enables
  output logic wr_o,               // Write strobe
  output logic rd_o,               // Read strobe
  output logic [31:0] wdata_o      // Write data
);
  initial begin
    addr_o = 8'hFF;
    be_o = 4'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 32'h0000_0000;
  end

  // Released lines except the byte enables show the inverse so stale values never look valid.
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] b,
                           input logic [31:0] d);
    @(negedge core_clk_i);
    addr_o = a;
    be_o = b;
    wdata_o = d & 32'hFFF0_03FF; // Reserved bits always go out as 0.
    wr_o = 1'b1;
    @(negedge core_clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~wdata_o;
  endtask : cfg_write

  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d,
                          output logic v);
    @(negedge core_clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge core_clk_i);
    d = rdata_i;
    v = rvalid_i;
    rd_o = 1'b0;
    addr_o = ~a;
  endtask : cfg_read
endmodule : gfxcs_host_model

/* File: tb/gfx_pci_cmd_status_regs_tb_top.sv */
// Self-checking bench for the command and status registers.
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  fail_count++; $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
  end end

module gfx_pci_cmd_status_regs_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr;
  logic [3:0] be;
  logic wr, rd, mem_hit, io_hit, par_err, rvalid;
  logic [31:0] wdata, rdata, d;
  logic v, mem_en, io_en, bm, mem_claim, io_claim, serr, serr_oe_b;
  int fail_count = 0;
  int cmp_count = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  gfxcs_host_model gfxcs_host_model_i (.core_clk_i(core_clk_i),
    .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr), .be_o(be),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

  gfxcs_regs gfxcs_regs_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wr_i(wr), .cfg_rd_i(rd),
    .cfg_wdata_i(wdata), .mem_hit_i(mem_hit), .io_hit_i(io_hit),
    .parity_err_i(par_err), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
    .mem_space_enable_o(mem_en), .io_space_enable_o(io_en),
    .bus_master_allow_o(bm), .mem_claim_o(mem_claim),
    .io_claim_o(io_claim), .serr_o(serr), .serr_oe_b_o(serr_oe_b));

  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  task automatic read_expect(input logic [7:0] a, input logic [31:0] exp);
    gfxcs_host_model_i.cfg_read(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, exp)
  endtask : read_expect

  // Both hits are raised together so a crossed enable shows up.
  task automatic hits_expect(input logic [1:0] en);
    @(negedge core_clk_i);
    mem_hit = 1'b1;
    io_hit = 1'b1;
    @(negedge core_clk_i);
    mem_hit = 1'b0;
    io_hit = 1'b0;
    `CHK({mem_claim, io_claim}, en)
    @(negedge core_clk_i);
    `CHK({mem_claim, io_claim}, 2'h0)
  endtask : hits_expect

  initial begin
    mem_hit = 1'b0;
    io_hit = 1'b0;
    par_err = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    `CHK({bm, serr, serr_oe_b}, 3'h5)
    read_expect(8'h04, 32'h02B0_0004);
    hits_expect(2'h0);
    // Every enable pattern, with ones written into the read-only bits outside 19:10, which the host model sends as 0.
    for (int i = 0; i < 4; i++) begin
      gfxcs_host_model_i.cfg_write(8'h04, 4'hF, 32'hFFFF_FFFC | i);
      `CHK({mem_en, io_en}, i[1:0])
      read_expect(8'h06, 32'h02B0_0004 | i);
      read_expect(8'h05, 32'h02B0_0004 | i);
      hits_expect(i[1:0]);
    end
    gfxcs_host_model_i.cfg_write(8'h04, 4'hE, 32'h0000_0000);
    gfxcs_host_model_i.cfg_write(8'h08, 4'hF, 32'h0000_0000);
    par_err = 1'b1;
    read_expect(8'h04, 32'h02B0_0007);
    par_err = 1'b0;
    read_expect(8'h08, 32'h0000_0000);
    `CHK({serr, serr_oe_b}, 2'h1)
    rst_b_i = 1'b0;
    @(negedge core_clk_i);
    `CHK({mem_en, io_en, bm}, 3'h1)
    rst_b_i = 1'b1;
    read_expect(8'h04, 32'h02B0_0004);
    tally_and_finish();
  end

  initial begin
    #(25 * 2000);
    fail_count++;
    tally_and_finish();
  end
endmodule : gfx_pci_cmd_status_regs_tb_top
